// ==== verilog/irq_vector_map.sv ====
// interrupt source to vector map with flags, enables, priorities and selection
// ----------------------------------------
// Summary of operation
// - the core timer is irq 0 on vector 0, flag and enable bit 0 of the low words, priority word 0 bits 4:2 and 1:0.
// - core software interrupts a and b are irqs 1 and 2 on vectors 1 and 2 with fields at 12:10/9:8 and 20:18/17:16 of priority word 0.
// - external pin a is irq 3 on vector 3 with fields at 28:26 and 25:24 of priority word 0 and is edge (non-persistent).
// - capture 1 error and event are irqs 5 and 6, both on vector 5 with one shared field pair, both persistent.
// - adc conversion done is irq 28 on vector 23 and is persistent.
// - the clock monitor is irq 29 on vector 24 with fields at bits 4:2 and 1:0 of priority word 6 and is non-persistent.
// - the calendar clock is irq 30 on vector 25 with flag and enable at bit 30 of the low words.
// - the flash event is irq 31 on vector 26 at bit 31 of the low words and is non-persistent.
// - irq 32 and above sit in the high words at bit n minus 32, comparator a being irq 32 on vector 27.
// - usb is irq 35 on vector 30 with its flag at bit 3 of the high flag word and is persistent.
// - capture 2 error and event (irqs 10 and 11) share vector 9 and one field in priority word 2, both persistent.
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none

module irq_vector_map
	import irq_map_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic [38:0] irq_src_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_req_o,
	output logic [4:0] irq_vector_o,
	output logic [2:0] irq_level_o
);

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic logic [31:0] be_merge(input logic [31:0] old_w,
			input logic [31:0] new_w, input logic [3:0] be);
		logic [31:0] r;
		r = old_w;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_w[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [2:0] pri_field(input logic [31:0] w, input logic [1:0] slot);
		return w[int'(slot) * SLOT_STRIDE + PRI_LSB +: 3];
	endfunction

	function automatic logic [1:0] sub_field(input logic [31:0] w, input logic [1:0] slot);
		return w[int'(slot) * SLOT_STRIDE + SUB_LSB +: 2];
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [38:0] flag_q;
	logic [38:0] flag_d;
	logic [38:0] enable_q;
	logic [38:0] src_prev_q;
	logic [31:0] pri_q [0:7];
	logic wait_q;
	logic [31:0] rdata_q;
	logic req_q;
	logic [4:0] vec_q;
	logic [2:0] lvl_q;

	logic [38:0] set_vec;
	logic [38:0] pend_w;
	logic wr_go;
	logic rd_take;
	logic sel_found;
	logic [4:0] sel_vec;
	logic [2:0] sel_pri;
	logic [1:0] sel_sub;
	logic [5:0] sel_irq;
	logic [31:0] rd_mux;
	logic [2:0] pri_idx;
	logic [31:0] flag_hi_merge;
	logic [31:0] enable_hi_merge;

	assign wr_go = avs_write_i && !wait_q;
	assign rd_take = avs_read_i && wait_q;
	assign pend_w = flag_q & enable_q;
	// priority word index counted from the first priority address
	assign pri_idx = 3'(avs_address_i - ADDR_PRIORITY_WORD_0);
	assign flag_hi_merge = be_merge({25'h0000000, flag_q[38:32]}, avs_writedata_i,
		avs_byteenable_i);
	assign enable_hi_merge = be_merge({25'h0000000, enable_q[38:32]}, avs_writedata_i,
		avs_byteenable_i);

	// ----------------------------------------
	// avalon handshake
	// ----------------------------------------
	// one wait cycle then a single low cycle per request
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			wait_q <= 1'b1;
		end else if (wait_q && (avs_read_i || avs_write_i)) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			rdata_q <= RESET_WORD;
		end else if (rd_take) begin
			rdata_q <= rd_mux;
		end
	end

	// read decode, unmapped reads as zero
	always_comb begin
		rd_mux = RESET_WORD;
		if (avs_address_i == ADDR_FLAG_WORD_LOW) begin
			rd_mux = flag_q[31:0];
		end else if (avs_address_i == ADDR_FLAG_WORD_HIGH) begin
			rd_mux = {25'h0000000, flag_q[38:32]};
		end else if (avs_address_i == ADDR_ENABLE_WORD_LOW) begin
			rd_mux = enable_q[31:0];
		end else if (avs_address_i == ADDR_ENABLE_WORD_HIGH) begin
			rd_mux = {25'h0000000, enable_q[38:32]};
		end else if (avs_address_i >= ADDR_PRIORITY_WORD_0 &&
				avs_address_i <= ADDR_PRIORITY_WORD_7) begin
			rd_mux = pri_q[pri_idx];
		end else if (avs_address_i == ADDR_SELECT_STATUS) begin
			rd_mux = {23'h000000, req_q, lvl_q, vec_q};
		end
	end

	// ----------------------------------------
	// flags and enables
	// ----------------------------------------
	// persistent sources set on level, the rest on a rising edge
	assign set_vec = (irq_src_i & PERSIST_MASK) |
		(irq_src_i & ~src_prev_q & ~PERSIST_MASK);

	// software write first, hardware set wins over a clear
	always_comb begin
		flag_d = flag_q;
		if (wr_go && avs_address_i == ADDR_FLAG_WORD_LOW) begin
			flag_d[31:0] = be_merge(flag_q[31:0], avs_writedata_i, avs_byteenable_i);
		end else if (wr_go && avs_address_i == ADDR_FLAG_WORD_HIGH) begin
			flag_d[38:32] = flag_hi_merge[6:0];
		end
		flag_d = flag_d | set_vec;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			flag_q <= RESET_FLAGS;
			src_prev_q <= RESET_FLAGS;
		end else begin
			flag_q <= flag_d;
			src_prev_q <= irq_src_i;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			enable_q <= RESET_FLAGS;
		end else if (wr_go && avs_address_i == ADDR_ENABLE_WORD_LOW) begin
			enable_q[31:0] <= be_merge(enable_q[31:0], avs_writedata_i, avs_byteenable_i);
		end else if (wr_go && avs_address_i == ADDR_ENABLE_WORD_HIGH) begin
			enable_q[38:32] <= enable_hi_merge[6:0];
		end
	end

	// ----------------------------------------
	// priority words
	// ----------------------------------------
	// four vectors per word, unused bits held at zero
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			for (int w = 0; w < NUM_PRI_WORDS; w++) begin
				pri_q[w] <= RESET_WORD;
			end
		end else if (wr_go && avs_address_i >= ADDR_PRIORITY_WORD_0 &&
				avs_address_i <= ADDR_PRIORITY_WORD_7) begin
			pri_q[pri_idx] <= be_merge(pri_q[pri_idx],
				avs_writedata_i, avs_byteenable_i) & PRI_WORD_MASK;
		end
	end

	// ----------------------------------------
	// vector selection
	// ----------------------------------------
	// ascending scan, only a strictly higher key replaces the pick
	always_comb begin
		logic [4:0] v;
		logic [2:0] p;
		logic [1:0] s;
		v = 5'h00;
		p = 3'h0;
		s = 2'h0;
		sel_found = 1'b0;
		sel_vec = 5'h00;
		sel_pri = 3'h0;
		sel_sub = 2'h0;
		sel_irq = 6'h00;
		for (int i = 0; i < NUM_IRQ; i++) begin
			v = VEC_OF_IRQ[i];
			p = pri_field(pri_q[v[4:2]], v[1:0]);
			s = sub_field(pri_q[v[4:2]], v[1:0]);
			if (pend_w[i] && p != PRI_OFF &&
					(!sel_found || {p, s} > {sel_pri, sel_sub})) begin
				sel_found = 1'b1;
				sel_vec = v;
				sel_pri = p;
				sel_sub = s;
				sel_irq = 6'(i);
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			req_q <= 1'b0;
			vec_q <= 5'h00;
			lvl_q <= 3'h0;
		end else begin
			req_q <= sel_found;
			vec_q <= sel_vec;
			lvl_q <= sel_pri;
		end
	end

	assign avs_readdata_o = rdata_q;
	assign avs_waitrequest_o = wait_q;
	assign irq_req_o = req_q;
	assign irq_vector_o = vec_q;
	assign irq_level_o = lvl_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	bus_answer_once_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("bus request not answered in one cycle");

	timer_vector_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		pend_w == 39'h1 && pri_q[0][4:2] != 3'h0 |=> irq_req_o && irq_vector_o == 5'h00 &&
		irq_level_o == $past(pri_q[0][4:2]))
		else $error("core timer did not select vector 0");

	soft_b_vector_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		pend_w == 39'h4 && pri_q[0][20:18] != 3'h0 |=> irq_vector_o == 5'h02 &&
		irq_level_o == $past(pri_q[0][20:18]))
		else $error("software interrupt b wrong vector or level");

	pin_edge_only_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		$rose(flag_q[3]) |-> ($past(irq_src_i[3]) && !$past(src_prev_q[3])) ||
		($past(wr_go) && $past(avs_address_i) == ADDR_FLAG_WORD_LOW))
		else $error("external pin flag set without an edge");

	capture_one_share_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(pend_w == 39'h40 || pend_w == 39'h20) && pri_q[1][12:10] != 3'h0
		|=> irq_vector_o == 5'h05)
		else $error("capture 1 request not on vector 5");

	persist_refill_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		irq_src_i[28] |=> flag_q[28])
		else $error("persistent adc flag not set while active");

	adc_vector_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		pend_w == 39'h1000_0000 && pri_q[5][28:26] != 3'h0 |=> irq_vector_o == 5'h17)
		else $error("adc not on vector 23");

	monitor_vector_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		pend_w == 39'h2000_0000 && pri_q[6][4:2] != 3'h0
		|=> irq_vector_o == 5'h18 && irq_level_o == $past(pri_q[6][4:2]))
		else $error("clock monitor wrong vector or level");

	calendar_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		irq_src_i[30] && !src_prev_q[30] |=> flag_q[30])
		else $error("calendar event did not set bit 30");

	flash_vector_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		pend_w == 39'h8000_0000 && pri_q[6][20:18] != 3'h0 |=> irq_vector_o == 5'h1A)
		else $error("flash event not on vector 26");

	high_word_bit_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		irq_src_i[32] && !src_prev_q[32] |=> flag_q[32])
		else $error("comparator a not at high bit 0");

	high_word_read_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		rd_take && avs_address_i == ADDR_FLAG_WORD_HIGH
		|=> avs_readdata_o == {25'h0000000, $past(flag_q[38:32])})
		else $error("high flag word read back wrong");

	low_word_read_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		rd_take && avs_address_i == ADDR_FLAG_WORD_LOW
		|=> avs_readdata_o == $past(flag_q[31:0]))
		else $error("low flag word read back wrong");

	usb_vector_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		pend_w == 39'h08_0000_0000 && pri_q[7][20:18] != 3'h0 |=> irq_vector_o == 5'h1E)
		else $error("usb not on vector 30");

	serial_share_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		pend_w[31:0] == 32'h0 && pend_w[38:36] != 3'h0 && pend_w[35:32] == 4'h0 &&
		pri_q[7][28:26] != 3'h0 |=> irq_vector_o == 5'h1F && irq_level_o == $past(pri_q[7][28:26]))
		else $error("serial 1 request not on vector 31");

	capture_two_share_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		(pend_w == 39'h400 || pend_w == 39'h800) && pri_q[2][12:10] != 3'h0
		|=> irq_vector_o == 5'h09)
		else $error("capture 2 request not on vector 9");

	tie_lowest_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		pend_w == 39'h3 && pri_q[0][4:0] == pri_q[0][12:8] && pri_q[0][4:2] != 3'h0
		|=> irq_vector_o == 5'h00)
		else $error("tie not resolved to lowest irq");

	pri_mask_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		wr_go && avs_address_i == ADDR_PRIORITY_WORD_0 |=> (pri_q[0] & ~PRI_WORD_MASK) == 32'h0)
		else $error("reserved priority bits written");

	pri_word_read_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		rd_take && avs_address_i == ADDR_PRIORITY_WORD_7
		|=> avs_readdata_o == $past(pri_q[7]))
		else $error("priority word 7 read back wrong");

	zero_pri_off_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		pend_w == 39'h1 && pri_q[0][4:2] == 3'h0
		|=> !irq_req_o)
		else $error("priority 0 source was selected");

	edge_flag_stays_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		!flag_q[0] && !(irq_src_i[0] && !src_prev_q[0]) &&
		!(wr_go && avs_address_i == ADDR_FLAG_WORD_LOW) |=> !flag_q[0])
		else $error("non-persistent flag set without an event");

	none_pending_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		pend_w == 39'h00_0000_0000
		|=> !irq_req_o && irq_vector_o == 5'h00 && irq_level_o == 3'h0)
		else $error("request shown with nothing pending");

endmodule

`default_nettype wire

// ==== verilog/irq_map_pkg.sv ====
// package: register offsets, field layout and source tables of the interrupt vector map
package irq_map_pkg;

	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int NUM_IRQ = 39;
	localparam int NUM_VEC = 32;
	localparam int NUM_PRI_WORDS = 8;
	localparam int FIRST_HIGH_IRQ = 32;

	// ----------------------------------------
	// register word offsets
	// ----------------------------------------
	localparam logic [3:0] ADDR_FLAG_WORD_LOW = 4'h0;
	localparam logic [3:0] ADDR_FLAG_WORD_HIGH = 4'h1;
	localparam logic [3:0] ADDR_ENABLE_WORD_LOW = 4'h2;
	localparam logic [3:0] ADDR_ENABLE_WORD_HIGH = 4'h3;
	localparam logic [3:0] ADDR_PRIORITY_WORD_0 = 4'h4;
	localparam logic [3:0] ADDR_PRIORITY_WORD_7 = 4'hB;
	localparam logic [3:0] ADDR_SELECT_STATUS = 4'hC;

	// ----------------------------------------
	// field layout and masks
	// ----------------------------------------
	localparam int SLOT_STRIDE = 8;
	localparam int PRI_LSB = 2;
	localparam int SUB_LSB = 0;
	localparam logic [31:0] PRI_WORD_MASK = 32'h1F1F1F1F;
	localparam logic [31:0] HIGH_WORD_MASK = 32'h0000007F;
	localparam logic [2:0] PRI_OFF = 3'h0;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [31:0] RESET_WORD = 32'h00000000;
	localparam logic [38:0] RESET_FLAGS = 39'h00_0000_0000;

	// ----------------------------------------
	// source tables
	// ----------------------------------------
	// irq number to vector number
	localparam logic [4:0] VEC_OF_IRQ [0:38] = '{
		5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h05, 5'h06,
		5'h07, 5'h08, 5'h09, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
		5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h11, 5'h12, 5'h13,
		5'h14, 5'h15, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A,
		5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h1F, 5'h1F, 5'h1F
	};
	// sources whose flag is set again on every cycle the request level is high
	localparam logic [38:0] PERSIST_MASK = 39'h78_1631_8C60;

endpackage

// ==== verif/irq_requester_model.sv ====
// requester model: registered request levels of the peripheral interrupt sources
`timescale 1ns/1ps
`default_nettype none

module irq_requester_model (
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic [38:0] level_i,
	output logic [38:0] irq_src_o
);
	// ----------------------------------------
	// request levels
	// ----------------------------------------
	// levels launch just after the edge and stay until the source drops them
	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			irq_src_o <= 39'h00_0000_0000;
		end else begin
			irq_src_o <= level_i;
		end
	end
endmodule

`default_nettype wire

// ==== verif/tb_irq_vector_map.sv ====
// testbench: register bus, source mapping, persistence and selection of the vector map
`timescale 1ns/1ps
`default_nettype none

module tb_irq_vector_map;
	// ----------------------------------------
	// signals and expected tables
	// ----------------------------------------
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [38:0] src_level = 39'h00_0000_0000;
	logic [38:0] irq_src;
	logic [3:0] address = 4'h0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hF;
	logic [31:0] readdata;
	logic waitrequest;
	logic irq_req;
	logic [4:0] irq_vector;
	logic [2:0] irq_level;
	int n_errors = 0;
	int checks = 0;
	int i;
	logic [31:0] rd;
	logic [31:0] bitv;
	logic [4:0] v;
	logic [3:0] fa;
	logic [3:0] pw;
	localparam logic [38:0] EXP_PERSIST = 39'h78_1631_8C60;
	localparam logic [4:0] EXP_VEC [0:38] = '{
		5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h05, 5'h06, 5'h07, 5'h08,
		5'h09, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0D, 5'h0E, 5'h0F, 5'h10,
		5'h11, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h15, 5'h16, 5'h17, 5'h18,
		5'h19, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h1F, 5'h1F, 5'h1F};
	localparam logic [15:0] PRI_CASES [0:4] = '{16'h0D0D, 16'h0E0D, 16'h0D11, 16'h0D00, 16'h0D00};
	localparam logic [31:0] EN_CASES [0:4] = '{32'h3, 32'h3, 32'h3, 32'h3, 32'h1};
	localparam logic [31:0] STAT_CASES [0:4] = '{32'h160, 32'h161, 32'h180, 32'h161, 32'h0};

	irq_requester_model requester (
		.sys_clk_i(sys_clk),
		.rstn_i(rstn),
		.level_i(src_level),
		.irq_src_o(irq_src)
	);

	irq_vector_map dut (
		.sys_clk_i(sys_clk),
		.rstn_i(rstn),
		.irq_src_i(irq_src),
		.avs_address_i(address),
		.avs_read_i(read),
		.avs_write_i(write),
		.avs_writedata_i(writedata),
		.avs_byteenable_i(byteenable),
		.avs_readdata_o(readdata),
		.avs_waitrequest_o(waitrequest),
		.irq_req_o(irq_req),
		.irq_vector_o(irq_vector),
		.irq_level_o(irq_level)
	);

	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// bus tasks and compare
	// ----------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus_access(input logic wr, input logic [3:0] a, input logic [31:0] d,
			input logic [3:0] be, output logic [31:0] q);
		address <= a;
		writedata <= d;
		byteenable <= be;
		read <= !wr;
		write <= wr;
		do begin
			@(posedge sys_clk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus_access(1'b1, a, d, 4'hF, q);
	endtask

	task automatic bus_read(input logic [3:0] a, output logic [31:0] q);
		bus_access(1'b0, a, 32'h0, 4'hF, q);
	endtask

	task automatic settle();
		repeat (4) @(posedge sys_clk);
	endtask

	function automatic logic [31:0] stat(input logic [2:0] lvl, input logic [4:0] vec);
		return {23'h0, 1'b1, lvl, vec};
	endfunction

	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_errors++;
		end_of_test();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		@(posedge sys_clk);
		check({31'h0, waitrequest}, 32'h1);
		// reset values, unmapped places read zero
		for (i = 0; i < 16; i++) begin
			bus_read(i[3:0], rd);
			check(rd, 32'h0);
		end
		// reserved bits of each word
		for (i = 4; i < 12; i++) begin
			bus_write(i[3:0], 32'hFFFFFFFF);
			bus_read(i[3:0], rd);
			check(rd, 32'h1F1F1F1F);
			bus_write(i[3:0], 32'h0);
		end
		for (i = 0; i < 4; i++) begin
			bus_write(i[3:0], 32'hFFFFFFFF);
			bus_read(i[3:0], rd);
			check(rd, i[0] ? 32'h7F : 32'hFFFFFFFF);
			bus_write(i[3:0], 32'h0);
		end
		bus_write(4'hC, 32'hFFFFFFFF);
		bus_write(4'hD, 32'hFFFFFFFF);
		bus_read(4'hC, rd);
		check(rd, 32'h0);
		bus_read(4'hD, rd);
		check(rd, 32'h0);
		bus_access(1'b1, 4'h4, 32'hFFFFFFFF, 4'h2, rd);
		bus_read(4'h4, rd);
		check(rd, 32'h00001F00);
		bus_write(4'h4, 32'h0);
		// every source alone: vector, flag place, persistence
		for (i = 0; i < 39; i++) begin
			v = EXP_VEC[i];
			fa = (i >= 32) ? 4'h1 : 4'h0;
			bitv = 32'h1 << (i % 32);
			pw = 4'h4 + {1'b0, v[4:2]};
			bus_write(fa + 4'h2, bitv);
			bus_write(pw, 32'h16 << (8 * v[1:0]));
			src_level[i] <= 1'b1;
			settle();
			bus_read(4'hC, rd);
			check(rd, stat(3'h5, v));
			check({23'h0, irq_req, irq_level, irq_vector}, stat(3'h5, v));
			bus_read(fa, rd);
			check(rd, bitv);
			bus_write(fa, 32'h0);
			settle();
			bus_read(fa, rd);
			check(rd, EXP_PERSIST[i] ? bitv : 32'h0);
			src_level[i] <= 1'b0;
			settle();
			bus_write(fa, 32'h0);
			settle();
			bus_read(fa, rd);
			check(rd, 32'h0);
			bus_read(4'hC, rd);
			check(rd, 32'h0);
			check({23'h0, irq_req, irq_level, irq_vector}, 32'h0);
			bus_write(fa + 4'h2, 32'h0);
			bus_write(pw, 32'h0);
		end
		// selection between two flagged sources
		bus_write(4'h0, 32'h3);
		for (i = 0; i < 5; i++) begin
			bus_write(4'h2, EN_CASES[i]);
			bus_write(4'h4, {16'h0, PRI_CASES[i]});
			settle();
			bus_read(4'hC, rd);
			check(rd, STAT_CASES[i]);
			check({23'h0, irq_req, irq_level, irq_vector}, STAT_CASES[i]);
		end
		end_of_test();
	end
endmodule

`default_nettype wire
